// >>> bench/rss_host_model.sv
// Purpose: Host side that reads characters and their status codes
// Assumes: No back-pressure towards the block
// Notes: Keeps every output character with its code in arrival order
`timescale 1ns/1ns
module rss_host_model (
  input wire logic aclk,
  input wire logic rx_out_valid,
  input wire logic [7:0] rx_out_data,
  input wire logic [2:0] rx_char_status_code
);
  logic [10:0] q[$];
  always @(posedge aclk) begin
    if (rx_out_valid === 1'b1) q.push_back({rx_char_status_code, rx_out_data});
  end
endmodule

// >>> bench/rss_rx_status_chk.sv
// Purpose: Port-level assertions for the receive status block
// Assumes: One clock, synchronous active-low reset
// Notes: Fault inputs restart the character count used for lock
`timescale 1ns/1ns
module rss_rx_status_chk (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic rx_char_valid,
  input wire logic rx_ebuf_fault,
  input wire logic rx_pll_loss,
  input wire logic rx_out_valid,
  input wire logic [7:0] rx_out_data,
  input wire logic [2:0] rx_char_status_code,
  input wire logic rx_locked
);
  logic [3:0] n_char;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Characters since the last fault, saturating so it never wraps
  always_ff @(posedge aclk) begin
    if (!aresetn || rx_ebuf_fault || rx_pll_loss) n_char <= 4'h0;
    else if (rx_char_valid && n_char != 4'hf) n_char <= n_char + 4'h1;
  end
  AST_FAULT_CODE: assert property (
    rx_char_valid && rx_ebuf_fault ##1 rx_char_valid |=> rx_out_valid &&
    rx_char_status_code == 3'h5) else $error("buffer fault not coded");
  AST_VIOL_CHAR: assert property (
    rx_out_valid && rx_char_status_code == 3'h4 |-> rx_out_data == 8'he0)
    else $error("violation char wrong");
  AST_DISP_CHAR: assert property (
    rx_out_valid && rx_char_status_code == 3'h6 |-> rx_out_data == 8'he4)
    else $error("disparity char wrong");
  AST_EBUF_DROP: assert property (
    rx_ebuf_fault |-> ##2 !rx_locked) else $error("lock kept on fault");
  AST_PLL_DROP: assert property (
    rx_pll_loss |-> ##2 !rx_locked) else $error("lock kept on pll loss");
  AST_LOCK_FOUR: assert property (
    $rose(rx_locked) |-> n_char >= 4'h4) else $error("lock too early");
  AST_OUT_CAUSE: assert property (
    rx_out_valid |-> $past(rx_char_valid)) else $error("stray output");
  AST_OUT_HOLD: assert property (
    !rx_out_valid |-> $stable(rx_out_data) && $stable(rx_char_status_code))
    else $error("output moved");
  AST_RD_ANSWER: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("no read data");
  AST_WR_DONE: assert property (
    s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid) else $error("bvalid stuck");
  cover property ($rose(rx_locked));
  cover property (rx_out_valid && rx_char_status_code == 3'h2);
  cover property (rx_out_valid && rx_char_status_code == 3'h7);
endmodule
bind rss_rx_status rss_rx_status_chk u_rss_rx_status_chk (.*);

// >>> bench/rss_rx_status_tb.sv
// Purpose: Self-checking bench for the receive status block
// Assumes: Channels stay bonded, deskew window never expires
// Notes: Bench model predicts code and data of every character
`timescale 1ns/1ns
module rss_rx_status_tb;
  logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
  logic s_axi_rready, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, irq, rx_char_valid, rx_char_is_k, rx_code_violation;
  logic rx_disparity_error, rx_ebuf_fault, rx_pll_loss, rx_channels_bonded;
  logic rx_deskew_expired, rx_out_valid, rx_locked;
  logic [7:0] s_axi_awaddr, s_axi_araddr, rx_char_data, rx_out_data;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  logic [2:0] rx_char_status_code;
  logic [10:0] exq[$];
  int bad_count, tests_run, st, cf, de, imv, tb, bd;
  rss_rx_status u_rss_rx_status (.*);
  rss_host_model u_rss_host_model (.*);
  task cmp(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    logic aw, w, b;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    do begin
      @(negedge aclk);
      {aw, w, b, rsp} = {s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_bresp};
      @(posedge aclk);
      if (aw) s_axi_awvalid <= 1'b0;
      if (w) s_axi_wvalid <= 1'b0;
    end while (!b);
    s_axi_bready <= 1'b0;
  endtask
  task rdr(input logic [7:0] a);
    logic ar, r;
    @(posedge aclk);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    do begin
      @(negedge aclk);
      {ar, r, rsp, rd} = {s_axi_arready, s_axi_rvalid, s_axi_rresp, s_axi_rdata};
      @(posedge aclk);
      if (ar) s_axi_arvalid <= 1'b0;
    end while (!r);
    s_axi_rready <= 1'b0;
  endtask
  // One character; f holds pll, buffer fault, disparity, violation
  task ch(input logic [7:0] d, input logic k, input logic [3:0] f);
    logic fr, er, ab;
    logic [2:0] c;
    @(posedge aclk);
    {rx_char_valid, rx_char_data, rx_char_is_k} <= {1'b1, d, k};
    {rx_pll_loss, rx_ebuf_fault, rx_disparity_error, rx_code_violation} <= f;
    fr = k && d == 8'hbc && f[1:0] == 2'h0;
    er = |f[1:0];
    ab = |f[3:2];
    if (ab || bd && st == 0) c = 3'h5;
    else if (st == 1) c = 3'h7;
    else if (f[0]) c = 3'h4;
    else if (fr) c = 3'h3;
    else if (f[1]) c = 3'h6;
    else c = {2'h0, k};
    if (st == 0 && fr && !ab) {st, cf} = {32'd1, 32'd1};
    else if (st == 1 && (ab || er)) st = 0;
    else if (st == 1) begin
      cf = fr ? cf + 1 : 0;
      if (cf == 4) {st, de, imv} = {32'd3, 64'd0};
    end else if (st >= 2) begin
      de = er ? de + 1 : 0;
      imv = er ? imv + 1 : (imv > 0 ? imv - 1 : 0);
      if (ab || de == 4 || imv == 4) st = 0;
      else if (st == 3 && !fr && !er) begin
        st = 2;
        if (tb && bd && exq[$][10:8] != 3'h5) exq[$][10:8] = 3'h2;
      end
    end
    exq.push_back({c, c == 3'h4 ? 8'he0 : c == 3'h6 ? 8'he4 : d});
  endtask
  task idle(input int n);
    repeat (n) begin
      @(posedge aclk);
      {rx_char_valid, rx_pll_loss, rx_ebuf_fault, rx_disparity_error} <= 4'h0;
      rx_code_violation <= 1'b0;
    end
  endtask
  task drain;
    logic [10:0] h;
    @(negedge aclk);
    while (u_rss_host_model.q.size() > 0) begin
      h = u_rss_host_model.q.pop_front();
      cmp({21'h0, h}, {21'h0, exq.pop_front()});
    end
    cmp(exq.size(), 1);
  endtask
  task results;
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end
  // Whole run is under a hundred cycles
  initial begin
    #200000;
    bad_count++;
    results;
  end
  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = 5'h0;
    {s_axi_rready, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 49'h0;
    {s_axi_wstrb, rx_channels_bonded, rx_deskew_expired} = 6'h3e;
    {rx_char_data, rx_char_is_k} = 9'h0;
    {rx_char_valid, rx_pll_loss, rx_ebuf_fault, rx_disparity_error} = 4'h0;
    rx_code_violation = 1'b0;
    bd = 1;
    void'($urandom(4341));
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    rdr(rss_pkg::REG_CTRL);
    cmp(rd, 32'h6);
    rdr(rss_pkg::REG_FRAMING);
    cmp(rd, 32'h1bc);
    rdr(8'h40);
    cmp({30'h0, rsp}, 32'h2);
    wr(8'h40, 32'h0);
    cmp({30'h0, rsp}, 32'h2);
    // Type-A, channels independent, decoder on
    wr(rss_pkg::REG_CTRL, 32'h4);
    bd = 0;
    repeat (4) ch(8'hbc, 1'b1, 4'h0);
    repeat (8) ch(8'($urandom), 1'b0, 4'h0);
    ch(8'h1c, 1'b1, 4'h0);
    ch(8'h55, 1'b0, 4'h1);
    ch(8'h55, 1'b0, 4'h2);
    repeat (2) ch(8'h77, 1'b0, 4'h0);
    idle(2);
    cmp({31'h0, rx_locked}, {31'h0, st >= 2});
    drain;
    repeat (4) ch(8'h55, 1'b0, 4'h1);
    ch(8'h55, 1'b0, 4'h4);
    ch(8'h66, 1'b0, 4'h0);
    idle(2);
    cmp({31'h0, rx_locked}, {31'h0, st >= 2});
    drain;
    // Interrupt is sticky, masked, cleared by writing ones
    cmp({31'h0, irq}, 32'h0);
    wr(rss_pkg::REG_IRQ_MASK, 32'h4);
    idle(2);
    cmp({31'h0, irq}, 32'h1);
    wr(rss_pkg::REG_IRQ_STATUS, 32'h3f);
    idle(2);
    cmp({31'h0, irq}, 32'h0);
    // Type-B bonded: lock detect on the last framing character
    wr(rss_pkg::REG_CTRL, 32'h7);
    {tb, bd} = {32'd1, 32'd1};
    repeat (4) ch(8'hbc, 1'b1, 4'h0);
    ch(8'h11, 1'b0, 4'h0);
    ch(8'h22, 1'b0, 4'h8);
    ch(8'h33, 1'b0, 4'h0);
    idle(2);
    drain;
    results;
  end
endmodule

// >>> logic/rss_pkg.sv
// Purpose: Shared constants and types for the receive sync and status block
// Assumes: AXI4-Lite register access with 32-bit data, byte addresses
// Notes: Status codes, replacement characters and register map live here
package rss_pkg;
  // Register byte offsets
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] REG_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] REG_FRAMING = 8'h04;
  localparam logic [ADDR_W-1:0] REG_STATUS = 8'h08;
  localparam logic [ADDR_W-1:0] REG_IRQ_STATUS = 8'h0c;
  localparam logic [ADDR_W-1:0] REG_IRQ_MASK = 8'h10;

  // Control fields
  localparam int CTRL_W = 3;
  localparam int CTRL_MODE_BIT = 0;
  localparam int CTRL_BOND_BIT = 1;
  localparam int CTRL_DEC_BIT = 2;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 3'h6;

  // Framing character: bit 8 is the control-character flag
  localparam int FRAMING_W = 9;
  localparam int FRAMING_K_BIT = 8;
  localparam logic [FRAMING_W-1:0] FRAMING_RESET = 9'h1bc;

  // Status register fields
  localparam int STATUS_STATE_LSB = 0;
  localparam int STATUS_LOCKED_BIT = 2;

  // Interrupt bits
  localparam int IRQ_W = 6;
  localparam int IRQ_LOCK_GAINED = 0;
  localparam int IRQ_LOCK_LOST = 1;
  localparam int IRQ_CODEWORD = 2;
  localparam int IRQ_DISPARITY = 3;
  localparam int IRQ_EBUF = 4;
  localparam int IRQ_PLL = 5;
  localparam logic [IRQ_W-1:0] IRQ_MASK_RESET = 6'h00;

  // Character status codes
  localparam logic [2:0] ST_NORMAL = 3'h0;
  localparam logic [2:0] ST_SPECIAL = 3'h1;
  localparam logic [2:0] ST_LOCK_DET = 3'h2;
  localparam logic [2:0] ST_FRAMING = 3'h3;
  localparam logic [2:0] ST_CODEWORD = 3'h4;
  localparam logic [2:0] ST_LOSS = 3'h5;
  localparam logic [2:0] ST_DISPARITY = 3'h6;
  localparam logic [2:0] ST_RESYNC = 3'h7;

  // Replacement characters
  localparam logic [7:0] CHAR_C0_7 = 8'he0;
  localparam logic [7:0] CHAR_C4_7 = 8'he4;

  // Sync machine counts
  localparam int CNT_W = 3;
  localparam logic [CNT_W-1:0] FRAMING_LOCK_COUNT = 3'h4;
  localparam logic [CNT_W-1:0] DEC_ERR_LIMIT = 3'h4;
  localparam logic [CNT_W-1:0] INV_MINUS_VALID_LIMIT = 3'h4;

  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    SYNC_NONE,
    SYNC_REACQ,
    SYNC_LOCKED,
    SYNC_LOCKED_REACQ
  } rss_sync_e;
endpackage

// >>> logic/rss_rx_status.sv
// Purpose: Receive character status coding, sync tracking and register file
// Assumes: Decoded characters arrive with per-character error flags
// Notes: Output lags the input by one character for the lock-detect look-ahead
//
// Summary of operation
// RULE1 - Bonded: framing character match gives code 011 with decoded value.
// RULE2 - Undecodable character becomes C0.7 with code 100.
// RULE3 - Bonded: framing or alignment loss gives code 101.
// RULE4 - Independent with decoder on: PLL out of lock gives code 101.
// RULE5 - Elasticity buffer under/overflow gives code 101.
// RULE6 - Running disparity error gives replacement character and code 110.
// RULE7 - Reacquire state gives code 111 with decoded framing character.
// RULE8 - Lock needs framing character on four consecutive characters.
// RULE9 - Before lock, buffer fault, PLL loss or decoder error abandons sync.
// RULE10 - Locked: fault, PLL loss, four errors or invalid-valid of 4 drops lock.
// RULE11 - Type-A leaves locked-reacquire on a valid non-framing character.
// RULE12 - Type-B returns to reacquire on bond timeout or decoder error.
// RULE13 - Type-B abandons attempt when unbonded at deskew expiry.
// RULE14 - Type-B aligns only on last framing before valid data, when bonded.
// RULE15 - Type-B machine has four states: none, reacquire, locked, locked-reacquire.
// RULE16 - Mode select bit 0 picks Type-A or Type-B status reporting.
// RULE17 - Type-B bonded: code 010 on the last character before aligned data.
// RULE18 - Concurrent conditions report the lowest priority number.
// RULE19 - Framing character while unsynchronized enters reacquire.
//
// The address map and the AXI4-Lite register port were left to the implementer.
`timescale 1ns/1ns
module rss_rx_status (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [rss_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [rss_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic rx_char_valid,
  input wire logic [7:0] rx_char_data,
  input wire logic rx_char_is_k,
  input wire logic rx_code_violation,
  input wire logic rx_disparity_error,
  input wire logic rx_ebuf_fault,
  input wire logic rx_pll_loss,
  input wire logic rx_channels_bonded,
  input wire logic rx_deskew_expired,
  output logic rx_out_valid,
  output logic [7:0] rx_out_data,
  output logic [2:0] rx_char_status_code,
  output logic rx_locked,
  output logic irq
);
  rss_sync_if sif ();

  // Software state
  logic [rss_pkg::CTRL_W-1:0] ctrl, next_ctrl;
  logic [rss_pkg::FRAMING_W-1:0] framing_character, next_framing_character;
  logic [rss_pkg::IRQ_W-1:0] irq_status, next_irq_status, irq_mask, next_irq_mask;
  logic next_irq;

  // AXI slave state
  logic aw_got, next_aw_got, w_got, next_w_got, do_write;
  logic [rss_pkg::ADDR_W-1:0] aw_addr, next_aw_addr;
  logic [31:0] w_data, next_w_data, next_rdata;
  logic [3:0] w_strb, next_w_strb;
  logic next_awready, next_wready, next_bvalid, next_arready, next_rvalid;
  logic [1:0] next_bresp, next_rresp;

  // Character path state
  logic rx_status_mode_select, bond_en, dec_en, cv, de, is_framing, loss;
  logic [2:0] in_code, st_code, next_st_code, next_status_code;
  logic [7:0] in_data, st_data, next_st_data, next_out_data;
  logic st_valid, next_st_valid, next_out_valid, next_locked;
  logic [rss_pkg::IRQ_W-1:0] events;

  // RULE16 mode select bit
  assign rx_status_mode_select = ctrl[rss_pkg::CTRL_MODE_BIT];
  assign bond_en = ctrl[rss_pkg::CTRL_BOND_BIT];
  assign dec_en = ctrl[rss_pkg::CTRL_DEC_BIT];
  // Bypassed decoder reports no decode errors
  assign cv = rx_code_violation & dec_en;
  assign de = rx_disparity_error & dec_en;
  assign is_framing = ~cv & ~de &
    (rx_char_is_k == framing_character[rss_pkg::FRAMING_K_BIT]) &&
    (rx_char_data == framing_character[7:0]);

  // Events into the sync machine
  assign sif.char_valid = rx_char_valid;
  assign sif.is_framing = is_framing;
  assign sif.dec_error = cv | de;
  assign sif.valid_nonframe = ~cv & ~de & ~is_framing;
  assign sif.ebuf_fault = rx_ebuf_fault;
  assign sif.pll_loss = rx_pll_loss;
  assign sif.bonded = rx_channels_bonded;
  assign sif.deskew_expired = rx_deskew_expired;
  assign sif.type_b = rx_status_mode_select;

  // RULE15 four-state sync machine
  rss_sync_fsm u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .sif(sif)
  );

  // Status code of the incoming character, most urgent first
  always_comb begin
    // RULE3 RULE4 RULE5 loss of sync
    loss = rx_ebuf_fault | (rx_pll_loss & (bond_en | dec_en)) |
      (bond_en & ((sif.state == rss_pkg::SYNC_NONE) | (sif.locked & ~rx_channels_bonded)));
    in_data = rx_char_data;
    // RULE18 priority order
    if (loss) begin
      in_code = rss_pkg::ST_LOSS;
    // RULE7 reacquire reporting
    end else if (sif.state == rss_pkg::SYNC_REACQ) begin
      in_code = rss_pkg::ST_RESYNC;
    // RULE2 codeword violation
    end else if (cv) begin
      in_code = rss_pkg::ST_CODEWORD;
      in_data = rss_pkg::CHAR_C0_7;
    // RULE1 framing character
    end else if (is_framing) begin
      in_code = rss_pkg::ST_FRAMING;
    // RULE6 disparity error
    end else if (de) begin
      in_code = rss_pkg::ST_DISPARITY;
      in_data = rss_pkg::CHAR_C4_7;
    end else if (rx_char_is_k) begin
      in_code = rss_pkg::ST_SPECIAL;
    end else begin
      in_code = rss_pkg::ST_NORMAL;
    end
  end

  // One-character stage; the next character decides lock-detect
  always_comb begin
    next_st_valid = st_valid;
    next_st_data = st_data;
    next_st_code = st_code;
    next_out_valid = 1'b0;
    next_out_data = rx_out_data;
    next_status_code = rx_char_status_code;
    if (rx_char_valid) begin
      next_st_valid = 1'b1;
      next_st_data = in_data;
      next_st_code = in_code;
      next_out_valid = st_valid;
      if (st_valid) begin
        next_out_data = st_data;
        next_status_code = st_code;
        // RULE17 lock detected code
        if (sif.lock_detect && bond_en && st_code != rss_pkg::ST_LOSS) begin
          next_status_code = rss_pkg::ST_LOCK_DET;
        end
      end
    end
    next_locked = sif.locked;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_valid <= 1'b0;
      st_data <= 8'h00;
      st_code <= rss_pkg::ST_NORMAL;
      rx_out_valid <= 1'b0;
      rx_out_data <= 8'h00;
      rx_char_status_code <= rss_pkg::ST_NORMAL;
      rx_locked <= 1'b0;
    end else begin
      st_valid <= next_st_valid;
      st_data <= next_st_data;
      st_code <= next_st_code;
      rx_out_valid <= next_out_valid;
      rx_out_data <= next_out_data;
      rx_char_status_code <= next_status_code;
      rx_locked <= next_locked;
    end
  end

  // Interrupt sources; lock edges come from the registered lock flag
  always_comb begin
    events = '0;
    events[rss_pkg::IRQ_LOCK_GAINED] = sif.locked & ~rx_locked;
    events[rss_pkg::IRQ_LOCK_LOST] = ~sif.locked & rx_locked;
    events[rss_pkg::IRQ_CODEWORD] = rx_char_valid & cv;
    events[rss_pkg::IRQ_DISPARITY] = rx_char_valid & de;
    events[rss_pkg::IRQ_EBUF] = rx_ebuf_fault;
    events[rss_pkg::IRQ_PLL] = rx_pll_loss;
  end

  // AXI write and read channels plus register effects
  always_comb begin
    next_aw_got = aw_got;
    next_w_got = w_got;
    next_aw_addr = aw_addr;
    next_w_data = w_data;
    next_w_strb = w_strb;
    next_bvalid = s_axi_bvalid;
    next_bresp = s_axi_bresp;
    next_ctrl = ctrl;
    next_framing_character = framing_character;
    next_irq_mask = irq_mask;
    next_irq_status = irq_status;
    if (s_axi_awvalid && s_axi_awready) begin
      next_aw_got = 1'b1;
      next_aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_w_got = 1'b1;
      next_w_data = s_axi_wdata;
      next_w_strb = s_axi_wstrb;
    end
    if (s_axi_bvalid && s_axi_bready) begin
      next_bvalid = 1'b0;
    end
    do_write = aw_got & w_got & ~s_axi_bvalid;
    // Set wins over clear: a new event survives a same-cycle clear
    if (do_write) begin
      next_aw_got = 1'b0;
      next_w_got = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = rss_pkg::RESP_OKAY;
      if (aw_addr == rss_pkg::REG_CTRL) begin
        if (w_strb[0]) begin
          next_ctrl = w_data[rss_pkg::CTRL_W-1:0];
        end
      end else if (aw_addr == rss_pkg::REG_FRAMING) begin
        if (w_strb[0]) begin
          next_framing_character[7:0] = w_data[7:0];
        end
        if (w_strb[1]) begin
          next_framing_character[rss_pkg::FRAMING_K_BIT] = w_data[rss_pkg::FRAMING_K_BIT];
        end
      end else if (aw_addr == rss_pkg::REG_STATUS) begin
        next_bresp = rss_pkg::RESP_OKAY;
      end else if (aw_addr == rss_pkg::REG_IRQ_STATUS) begin
        if (w_strb[0]) begin
          next_irq_status = irq_status & ~w_data[rss_pkg::IRQ_W-1:0];
        end
      end else if (aw_addr == rss_pkg::REG_IRQ_MASK) begin
        if (w_strb[0]) begin
          next_irq_mask = w_data[rss_pkg::IRQ_W-1:0];
        end
      end else begin
        next_bresp = rss_pkg::RESP_SLVERR;
      end
    end
    next_irq_status = next_irq_status | events;
    next_awready = ~next_aw_got & ~next_bvalid;
    next_wready = ~next_w_got & ~next_bvalid;
    next_irq = |(next_irq_status & next_irq_mask);

    next_rvalid = s_axi_rvalid;
    next_rdata = s_axi_rdata;
    next_rresp = s_axi_rresp;
    if (s_axi_rvalid && s_axi_rready) begin
      next_rvalid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      next_rvalid = 1'b1;
      next_rdata = 32'h0000_0000;
      next_rresp = rss_pkg::RESP_OKAY;
      if (s_axi_araddr == rss_pkg::REG_CTRL) begin
        next_rdata[rss_pkg::CTRL_W-1:0] = ctrl;
      end else if (s_axi_araddr == rss_pkg::REG_FRAMING) begin
        next_rdata[rss_pkg::FRAMING_W-1:0] = framing_character;
      end else if (s_axi_araddr == rss_pkg::REG_STATUS) begin
        next_rdata[rss_pkg::STATUS_STATE_LSB+:2] = sif.state;
        next_rdata[rss_pkg::STATUS_LOCKED_BIT] = sif.locked;
      end else if (s_axi_araddr == rss_pkg::REG_IRQ_STATUS) begin
        next_rdata[rss_pkg::IRQ_W-1:0] = irq_status;
      end else if (s_axi_araddr == rss_pkg::REG_IRQ_MASK) begin
        next_rdata[rss_pkg::IRQ_W-1:0] = irq_mask;
      end else begin
        next_rresp = rss_pkg::RESP_SLVERR;
      end
    end
    // One read in flight; address is refused while data waits
    next_arready = ~next_rvalid;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got <= 1'b0;
      w_got <= 1'b0;
      aw_addr <= '0;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= rss_pkg::RESP_OKAY;
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= rss_pkg::RESP_OKAY;
      ctrl <= rss_pkg::CTRL_RESET;
      framing_character <= rss_pkg::FRAMING_RESET;
      irq_status <= '0;
      irq_mask <= rss_pkg::IRQ_MASK_RESET;
      irq <= 1'b0;
    end else begin
      aw_got <= next_aw_got;
      w_got <= next_w_got;
      aw_addr <= next_aw_addr;
      w_data <= next_w_data;
      w_strb <= next_w_strb;
      s_axi_awready <= next_awready;
      s_axi_wready <= next_wready;
      s_axi_bvalid <= next_bvalid;
      s_axi_bresp <= next_bresp;
      s_axi_arready <= next_arready;
      s_axi_rvalid <= next_rvalid;
      s_axi_rdata <= next_rdata;
      s_axi_rresp <= next_rresp;
      ctrl <= next_ctrl;
      framing_character <= next_framing_character;
      irq_status <= next_irq_status;
      irq_mask <= next_irq_mask;
      irq <= next_irq;
    end
  end
endmodule

// >>> logic/rss_sync_fsm.sv
// Purpose: Receive synchronization machine, Type-A and Type-B variants
// Assumes: One character per char_valid cycle
// Notes: lock_detect is a combinational pulse on the aligning character
`timescale 1ns/1ns
module rss_sync_fsm #(
  parameter logic [rss_pkg::CNT_W-1:0] LOCK_COUNT = rss_pkg::FRAMING_LOCK_COUNT,
  parameter logic [rss_pkg::CNT_W-1:0] ERR_LIMIT = rss_pkg::DEC_ERR_LIMIT,
  parameter logic [rss_pkg::CNT_W-1:0] DIFF_LIMIT = rss_pkg::INV_MINUS_VALID_LIMIT
) (
  input wire logic aclk,
  input wire logic aresetn,
  rss_sync_if.fsm sif
);
  rss_pkg::rss_sync_e state;
  rss_pkg::rss_sync_e next_state;
  logic [rss_pkg::CNT_W-1:0] frm_cnt;
  logic [rss_pkg::CNT_W-1:0] next_frm_cnt;
  logic [rss_pkg::CNT_W-1:0] err_cnt;
  logic [rss_pkg::CNT_W-1:0] next_err_cnt;
  logic [rss_pkg::CNT_W-1:0] diff_cnt;
  logic [rss_pkg::CNT_W-1:0] next_diff_cnt;
  logic fault;
  logic pre_abort;
  logic lock_abort;
  logic no_bond_window;
  logic lock_det;

  // Next state and counters
  always_comb begin
    next_state = state;
    next_frm_cnt = frm_cnt;
    next_err_cnt = err_cnt;
    next_diff_cnt = diff_cnt;
    lock_det = 1'b0;
    fault = sif.ebuf_fault | sif.pll_loss;
    no_bond_window = sif.type_b & ~sif.bonded & sif.deskew_expired;
    if (sif.char_valid) begin
      // Saturating so a long run never wraps back below the limit
      if (sif.is_framing) begin
        next_frm_cnt = (frm_cnt == LOCK_COUNT) ? frm_cnt : frm_cnt + 3'h1;
      end else begin
        next_frm_cnt = 3'h0;
      end
      if (sif.dec_error) begin
        next_err_cnt = (err_cnt == ERR_LIMIT) ? err_cnt : err_cnt + 3'h1;
        next_diff_cnt = (diff_cnt == DIFF_LIMIT) ? diff_cnt : diff_cnt + 3'h1;
      end else begin
        next_err_cnt = 3'h0;
        next_diff_cnt = (diff_cnt != 3'h0) ? diff_cnt - 3'h1 : diff_cnt;
      end
    end
    // RULE9 pre-lock aborts
    pre_abort = fault | (sif.char_valid & sif.dec_error);
    // RULE13 no bond by deskew expiry
    pre_abort = pre_abort | (sif.char_valid & no_bond_window);
    // RULE10 locked aborts
    lock_abort = fault | (next_err_cnt == ERR_LIMIT) | (next_diff_cnt == DIFF_LIMIT);
    case (state)
      rss_pkg::SYNC_NONE: begin
        // RULE19 framing starts reacquire
        if (sif.char_valid & sif.is_framing & ~pre_abort) begin
          next_state = rss_pkg::SYNC_REACQ;
        end
      end
      rss_pkg::SYNC_REACQ: begin
        if (pre_abort) begin
          next_state = rss_pkg::SYNC_NONE;
        // RULE8 four framing to lock
        end else if (next_frm_cnt == LOCK_COUNT) begin
          next_state = rss_pkg::SYNC_LOCKED_REACQ;
        end
      end
      rss_pkg::SYNC_LOCKED_REACQ: begin
        if (lock_abort) begin
          next_state = rss_pkg::SYNC_NONE;
        // RULE12 Type-B falls back
        end else if (sif.char_valid & sif.type_b & (no_bond_window | sif.dec_error)) begin
          next_state = rss_pkg::SYNC_REACQ;
        // RULE11 RULE14 valid data aligns
        end else if (sif.char_valid & sif.valid_nonframe & (~sif.type_b | sif.bonded)) begin
          next_state = rss_pkg::SYNC_LOCKED;
          lock_det = sif.type_b;
        end
      end
      rss_pkg::SYNC_LOCKED: begin
        if (lock_abort) begin
          next_state = rss_pkg::SYNC_NONE;
        end
      end
      default: next_state = rss_pkg::SYNC_NONE;
    endcase
    // Lock-time counters restart whenever lock is lost
    if (next_state == rss_pkg::SYNC_NONE || next_state == rss_pkg::SYNC_REACQ) begin
      next_err_cnt = 3'h0;
      next_diff_cnt = 3'h0;
    end
    if (next_state == rss_pkg::SYNC_NONE) begin
      next_frm_cnt = 3'h0;
    end
  end

  // State registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= rss_pkg::SYNC_NONE;
      frm_cnt <= 3'h0;
      err_cnt <= 3'h0;
      diff_cnt <= 3'h0;
    end else begin
      state <= next_state;
      frm_cnt <= next_frm_cnt;
      err_cnt <= next_err_cnt;
      diff_cnt <= next_diff_cnt;
    end
  end

  assign sif.state = state;
  assign sif.locked = (state == rss_pkg::SYNC_LOCKED) || (state == rss_pkg::SYNC_LOCKED_REACQ);
  assign sif.lock_detect = lock_det;
endmodule

// >>> logic/rss_sync_if.sv
// Purpose: Carries character events to the sync machine and its state back
// Assumes: Single clock domain
// Notes: Event inputs are meaningful only with char_valid, except faults
`timescale 1ns/1ns
interface rss_sync_if;
  logic char_valid;
  logic is_framing;
  logic dec_error;
  logic valid_nonframe;
  logic ebuf_fault;
  logic pll_loss;
  logic bonded;
  logic deskew_expired;
  logic type_b;
  rss_pkg::rss_sync_e state;
  logic locked;
  logic lock_detect;

  modport ctrl (
    output char_valid, is_framing, dec_error, valid_nonframe, ebuf_fault,
    output pll_loss, bonded, deskew_expired, type_b,
    input state, locked, lock_detect
  );
  modport fsm (
    input char_valid, is_framing, dec_error, valid_nonframe, ebuf_fault,
    input pll_loss, bonded, deskew_expired, type_b,
    output state, locked, lock_detect
  );
endinterface
